//--- hdl/dle_pkg.sv
// dle_pkg: offsets, field positions and reset values of the link-two irq block
// assumes: byte-wide register port, one clock, synchronous reset
package dle_pkg;
  localparam int          DLE_ADDR_W      = 8;
  localparam int          DLE_DATA_W      = 8;
  // ***************************************************************
  // register offsets
  // ***************************************************************
  localparam logic [7:0]  DLE_OFS_STATUS  = 8'h16;
  localparam logic [7:0]  DLE_OFS_ENABLE  = 8'h17;
  localparam logic [7:0]  DLE_OFS_RXFILL  = 8'h20;
  // ***************************************************************
  // field positions
  // ***************************************************************
  localparam int          DLE_BIT_TXBEGIN = 6;
  localparam int          DLE_BIT_RXBEGIN = 5;
  localparam int          DLE_BIT_TXFIN   = 4;
  localparam int          DLE_BIT_RXFIN   = 3;
  localparam int          DLE_BIT_FCS     = 2;
  localparam int          DLE_BIT_ABORT   = 1;
  localparam int          DLE_BIT_IDLE    = 0;
  localparam int          DLE_NUM_EVT     = 7;
  // ***************************************************************
  // reset values and masks
  // ***************************************************************
  localparam logic [7:0]  DLE_RST_ENABLE  = 8'h00;
  localparam logic [7:0]  DLE_RST_STATUS  = 8'h00;
  localparam logic [7:0]  DLE_ENABLE_MASK = 8'h7F;
  localparam logic [7:0]  DLE_RST_RDATA   = 8'h00;
endpackage

//--- hdl/dle_evt_if.sv
// dle_evt_if: event flags carried from the top module to the flag keeper
// assumes: one clock domain shared by both ends
`timescale 1ns/1ns
interface dle_evt_if;
  logic [6:0] evt;
  logic       clr;
  logic [6:0] flags;
  modport top  (output evt, output clr, input  flags);
  modport keep (input  evt, input  clr, output flags);
endinterface

//--- hdl/dle_flags.sv
// dle_flags: sticky event flags, cleared as a group on a status read
// assumes: clear pulse is one cycle, events are one-cycle pulses
`timescale 1ns/1ns
module dle_flags
  import dle_pkg::*;
(
  // clock and reset
  input  wire logic i_core_clk,
  input  wire logic i_rstn,
  // event side
  dle_evt_if.keep   evt_bus
);
  // ***************************************************************
  // sticky flags, set wins over clear
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < DLE_NUM_EVT; g++) begin : g_flag
      always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
          evt_bus.flags[g] <= DLE_RST_STATUS[g];
        end else if (evt_bus.evt[g]) begin
          evt_bus.flags[g] <= 1'b1;
        end else if (evt_bus.clr) begin
          evt_bus.flags[g] <= 1'b0;
        end
      end
    end
  endgenerate
endmodule

//--- hdl/dle_irq_top.sv
// dle_irq_top: interrupt enable and status for the second data link controller
// assumes: plain register port, one-cycle strobes, read data one cycle later
//
// Behaviour
// - tx begin irq only when its enable set
// - rx begin irq only when its enable set
// - tx finish irq only when its enable set
// - rx finish irq only when its enable set
// - enable bits: 1 enables, bits 6..0 read back written, bit 7 reads 0
// - status flags latch, clear on status read
// - rx buffer full also declares rx finish
`timescale 1ns/1ns
module dle_irq_top
  import dle_pkg::*;
(
  // clock and reset
  input  wire logic                        i_core_clk,
  input  wire logic                        i_rstn,
  // register port
  input  wire logic [dle_pkg::DLE_ADDR_W-1:0] i_addr,
  input  wire logic [dle_pkg::DLE_DATA_W-1:0] i_wdata,
  input  wire logic                        i_wr,
  input  wire logic                        i_rd,
  output logic      [dle_pkg::DLE_DATA_W-1:0] o_rdata,
  // controller events, one-cycle pulses; i_rx_buf_full is a level
  input  wire logic                        i_tx_begin_event,
  input  wire logic                        i_rx_begin_event,
  input  wire logic                        i_tx_finish_event,
  input  wire logic                        i_rx_finish_event,
  input  wire logic                        i_rx_buf_full,
  input  wire logic                        i_fcs_err_event,
  input  wire logic                        i_abort_event,
  input  wire logic                        i_idle_event,
  // interrupt
  output logic                             o_irq
);
  import dle_pkg::*;

  dle_evt_if evt_bus ();

  logic [7:0] data_link_two_irq_enable;
  logic       rx_full_d;
  logic       rx_fill_evt;
  logic [7:0] status_word;
  logic [7:0] next_rdata;

  // ***************************************************************
  // buffer full edge, counted as end of reception
  // ***************************************************************
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      rx_full_d <= 1'b0;
    end else begin
      rx_full_d <= i_rx_buf_full;
    end
  end
  assign rx_fill_evt = i_rx_buf_full & ~rx_full_d;

  // ***************************************************************
  // event bundle to the flag keeper
  // ***************************************************************
  always_comb begin
    evt_bus.evt                  = '0;
    evt_bus.evt[DLE_BIT_TXBEGIN] = i_tx_begin_event;
    evt_bus.evt[DLE_BIT_RXBEGIN] = i_rx_begin_event;
    evt_bus.evt[DLE_BIT_TXFIN]   = i_tx_finish_event;
    evt_bus.evt[DLE_BIT_RXFIN]   = i_rx_finish_event | rx_fill_evt;
    evt_bus.evt[DLE_BIT_FCS]     = i_fcs_err_event;
    evt_bus.evt[DLE_BIT_ABORT]   = i_abort_event;
    evt_bus.evt[DLE_BIT_IDLE]    = i_idle_event;
  end
  assign evt_bus.clr = i_rd && (i_addr == DLE_OFS_STATUS);

  dle_flags u_flags (
    .i_core_clk (i_core_clk),
    .i_rstn     (i_rstn),
    .evt_bus    (evt_bus)
  );

  assign status_word = {1'b0, evt_bus.flags};

  // ***************************************************************
  // enable register
  // ***************************************************************
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      data_link_two_irq_enable <= DLE_RST_ENABLE;
    end else if (i_wr && i_addr == DLE_OFS_ENABLE) begin
      data_link_two_irq_enable <= i_wdata & DLE_ENABLE_MASK;
    end
  end

  // ***************************************************************
  // read data, one cycle after the strobe
  // ***************************************************************
  always_comb begin
    next_rdata = DLE_RST_RDATA;
    if (i_rd) begin
      unique case (i_addr)
        DLE_OFS_STATUS: next_rdata = status_word;
        DLE_OFS_ENABLE: next_rdata = data_link_two_irq_enable;
        DLE_OFS_RXFILL: next_rdata = {7'h00, i_rx_buf_full};
        default:        next_rdata = DLE_RST_RDATA;
      endcase
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_rdata <= DLE_RST_RDATA;
    end else begin
      o_rdata <= next_rdata;
    end
  end

  // ***************************************************************
  // interrupt output, registered
  // ***************************************************************
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) begin
      o_irq <= 1'b0;
    end else begin
      // bits 6..0 gate ..
      o_irq <= |(status_word & data_link_two_irq_enable);
    end
  end
endmodule

//--- bench/dle_irq_top_asserts.sv
// dle_irq_top_asserts: port checks for the link-two irq block
// assumes: bound into dle_irq_top, one clock, sync reset
`timescale 1ns/1ns
module dle_irq_top_asserts
  import dle_pkg::*;
(
  // watched ports
  input wire logic       i_core_clk,
  input wire logic       i_rstn,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic       i_tx_begin_event,
  input wire logic       i_rx_begin_event,
  input wire logic       i_tx_finish_event,
  input wire logic       i_rx_finish_event,
  input wire logic       i_rx_buf_full,
  input wire logic       o_irq
);
  // **********
  // enable shadow and checks
  // **********
  logic [7:0] en;
  wire        we = i_wr && i_addr == DLE_OFS_ENABLE;
  wire        rs = i_rd && i_addr == DLE_OFS_STATUS;
  always_ff @(posedge i_core_clk) begin
    if (!i_rstn) en <= 8'h00;
    else if (we) en <= i_wdata;
  end
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  property p_rb; we ##2 i_rd && i_addr == DLE_OFS_ENABLE
    |=> o_rdata == ($past(i_wdata, 3) & 8'h7F); endproperty
  a_rb: assert property (p_rb) else $error("enable readback");
  property p_txb; i_tx_begin_event && en[6] && !i_wr |-> ##2 o_irq; endproperty
  a_txb: assert property (p_txb) else $error("tx begin irq");
  property p_rxb; i_rx_begin_event && en[5] && !i_wr |-> ##2 o_irq; endproperty
  a_rxb: assert property (p_rxb) else $error("rx begin irq");
  property p_txf; i_tx_finish_event && en[4] && !i_wr |-> ##2 o_irq; endproperty
  a_txf: assert property (p_txf) else $error("tx finish irq");
  property p_rxf; i_rx_finish_event && en[3] && !i_wr |-> ##2 o_irq; endproperty
  a_rxf: assert property (p_rxf) else $error("rx finish irq");
  property p_st; i_tx_begin_event ##1 !rs[*3] ##1 rs |=> o_rdata[6]; endproperty
  a_st: assert property (p_st) else $error("flag not latched");
  property p_buf; $rose(i_rx_buf_full) && en[3] && !i_wr ##1 !i_wr |-> ##2 o_irq; endproperty
  a_buf: assert property (p_buf) else $error("buffer full irq");
  property p_off; we && i_wdata == 8'h00 |-> ##2 !o_irq; endproperty
  a_off: assert property (p_off) else $error("irq while disabled");
  c_irq: cover property (o_irq);
  c_st: cover property (rs ##1 o_rdata != 8'h00);
  c_full: cover property ($rose(i_rx_buf_full));
endmodule
bind dle_irq_top dle_irq_top_asserts u_chk (.*);

//--- bench/tb_dle_irq_top.sv
// tb_dle_irq_top: self-checking bench for the link-two irq block
// assumes: package, design and checker compiled first
`timescale 1ns/1ns
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin failures++; \
  $display("BAD t=%0t got=%h exp=%h", $time, a, e); end end
module tb_dle_irq_top;
  import dle_pkg::*;
  logic       clk = 0, rstn = 0, wr = 0, rd = 0, full = 0, rd_d = 0, irq;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, e, v, q[$];
  logic [6:0] ev = 7'h00;
  int         failures = 0, check_count = 0, seed = 8, i;
  always #5 clk = ~clk;
  dle_irq_top u_dut (.i_core_clk(clk), .i_rstn(rstn), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_tx_begin_event(ev[6]),
    .i_rx_begin_event(ev[5]), .i_tx_finish_event(ev[4]), .i_rx_finish_event(ev[3]),
    .i_rx_buf_full(full), .i_fcs_err_event(ev[2]), .i_abort_event(ev[1]),
    .i_idle_event(ev[0]), .o_irq(irq));
  // **********
  // drivers, watcher, end of run
  // **********
  task automatic wreg(input logic [7:0] a, d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, x);
    q.push_back(x);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic look(input int n, input logic x);
    repeat (n) @(posedge clk);
    @(negedge clk);
    `CHK(irq, x)
  endtask
  task automatic fire(input logic [6:0] m, input logic x);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 7'h00;
    look(2, x);
  endtask
  task automatic stop_test;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk) rd_d <= rd;
  always @(negedge clk) begin
    if (rd_d) begin
      e = q.pop_front();
      `CHK(rdata, e)
    end
  end
  initial begin
    #50000;
    failures++;
    stop_test;
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rreg(DLE_OFS_ENABLE, DLE_RST_ENABLE);
    rreg(DLE_OFS_STATUS, DLE_RST_STATUS);
    for (i = 0; i < 4; i++) begin
      v = i ? $random(seed) : 8'hFF;
      wreg(DLE_OFS_ENABLE, v);
      rreg(DLE_OFS_ENABLE, v & DLE_ENABLE_MASK);
    end
    wreg(8'h55, 8'hFF);
    rreg(8'h55, 8'h00);
    $display("test registers done");
    for (i = 0; i < 7; i++) begin
      wreg(DLE_OFS_ENABLE, 8'h00);
      fire(7'h01 << i, 1'b0);
      rreg(DLE_OFS_STATUS, 8'h01 << i);
      wreg(DLE_OFS_ENABLE, 8'h01 << i);
      fire(7'h01 << i, 1'b1);
      wreg(DLE_OFS_ENABLE, 8'h00);
      look(2, 1'b0);
      rreg(DLE_OFS_STATUS, 8'h01 << i);
      rreg(DLE_OFS_STATUS, 8'h00);
    end
    $display("test events done");
    wreg(DLE_OFS_ENABLE, 8'h08);
    @(posedge clk);
    full <= 1'b1;
    look(4, 1'b1);
    rreg(DLE_OFS_RXFILL, 8'h01);
    rreg(DLE_OFS_STATUS, 8'h08);
    full <= 1'b0;
    rreg(DLE_OFS_STATUS, 8'h00);
    rreg(DLE_OFS_RXFILL, 8'h00);
    $display("test buffer full done");
    stop_test;
  end
endmodule
